/* File: rhai_pkg.sv */
// shared constants and types for the clock host access interface
package rhai_pkg;

    ////////////////////////////////////////////////////////////////////////
    // special-function-register map
    localparam logic [7:0] SFR_ADDR_CTRL = 8'hAC;
    localparam logic [7:0] SFR_DATA_PORT = 8'hAD;
    localparam logic [7:0] SFR_KEY_STATE = 8'hAE;

    ////////////////////////////////////////////////////////////////////////
    // key codes and lock state codes
    localparam logic [7:0] KEY_FIRST  = 8'hA5;
    localparam logic [7:0] KEY_SECOND = 8'hF1;

    typedef enum logic [1:0]
    {
        LOCK_LOCKED    = 2'b00,
        LOCK_FIRST_KEY = 2'b01,
        LOCK_UNLOCKED  = 2'b10,
        LOCK_DISABLED  = 2'b11
    } rhai_lock_t;

    localparam logic [7:0] KEY_RESET_VALUE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // address/control register fields
    localparam int unsigned BUSY_BIT   = 7;
    localparam int unsigned READ_ON_DATA_FETCH_ENABLE_BIT = 6;
    localparam int unsigned REGEN_BIT  = 5;
    localparam int unsigned SHORT_BIT  = 4;
    localparam int unsigned SEL_MSB    = 3;

    ////////////////////////////////////////////////////////////////////////
    // internal register select codes
    localparam logic [3:0] SEL_SNAP_LAST  = 4'h5;
    localparam logic [3:0] SEL_CONTROL    = 4'h6;
    localparam logic [3:0] SEL_OSC        = 4'h7;
    localparam logic [3:0] SEL_MATCH_FRST = 4'h8;
    localparam logic [3:0] SEL_MATCH_LAST = 4'hD;
    localparam logic [3:0] SEL_RAM_INDEX  = 4'hE;
    localparam logic [3:0] SEL_RAM_BYTE   = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // strobe widths in system clocks
    localparam logic [2:0] STROBE_LONG  = 3'h4;
    localparam logic [2:0] STROBE_SHORT = 3'h1;

    typedef enum logic [1:0]
    {
        XFER_IDLE  = 2'b00,
        XFER_READ  = 2'b01,
        XFER_WRITE = 2'b10
    } rhai_xfer_t;

    ////////////////////////////////////////////////////////////////////////
    // oscillator mode codes
    localparam logic [1:0] OSC_SELF_20K = 2'h0;
    localparam logic [1:0] OSC_SELF_40K = 2'h1;
    localparam logic [1:0] OSC_CRYSTAL  = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLOCK_MHZ          = 100;
    localparam int unsigned MCD_TIMEOUT_US     = 50;
    localparam int unsigned MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLOCK_MHZ;

    // snapshot and match bytes advance the select after each transfer
    function automatic logic rhai_autoinc(input logic [3:0] sel);
        rhai_autoinc = (sel <= SEL_SNAP_LAST)
                    || ((sel >= SEL_MATCH_FRST) && (sel <= SEL_MATCH_LAST));
    endfunction : rhai_autoinc

endpackage : rhai_pkg

/* File: rhai_key_fsm.sv */
// lock and key state machine guarding indirect access
`timescale 1ns/1ns
`default_nettype none

module rhai_key_fsm
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        key_wr_i,
    input  wire logic [7:0]  key_wdata_i,
    input  wire logic        bad_access_i,
    output rhai_pkg::rhai_lock_t state_o
);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            state_o <= rhai_pkg::LOCK_LOCKED;
        else
        begin
            unique case (state_o)
                rhai_pkg::LOCK_LOCKED:
                begin
                    if (bad_access_i)
                        state_o <= rhai_pkg::LOCK_DISABLED;
                    else if (key_wr_i)
                        state_o <= (key_wdata_i == rhai_pkg::KEY_FIRST)
                                 ? rhai_pkg::LOCK_FIRST_KEY
                                 : rhai_pkg::LOCK_DISABLED;
                end
                rhai_pkg::LOCK_FIRST_KEY:
                begin
                    if (bad_access_i)
                        state_o <= rhai_pkg::LOCK_DISABLED;
                    else if (key_wr_i)
                        state_o <= (key_wdata_i == rhai_pkg::KEY_SECOND)
                                 ? rhai_pkg::LOCK_UNLOCKED
                                 : rhai_pkg::LOCK_DISABLED;
                end
                rhai_pkg::LOCK_UNLOCKED:
                begin
                    if (key_wr_i)
                        state_o <= rhai_pkg::LOCK_LOCKED;
                end
                rhai_pkg::LOCK_DISABLED:
                    state_o <= rhai_pkg::LOCK_DISABLED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_key_unlock: assert property (@(posedge clock_i) disable iff (rst_i)
        key_wr_i && !bad_access_i && state_o == rhai_pkg::LOCK_FIRST_KEY
        && key_wdata_i == rhai_pkg::KEY_SECOND
        |=> state_o == rhai_pkg::LOCK_UNLOCKED)
        else $error("second key did not unlock");

    a_key_wrong: assert property (@(posedge clock_i) disable iff (rst_i)
        key_wr_i && state_o == rhai_pkg::LOCK_FIRST_KEY
        && key_wdata_i != rhai_pkg::KEY_SECOND
        |=> state_o == rhai_pkg::LOCK_DISABLED)
        else $error("wrong second key did not disable");

    a_key_relock: assert property (@(posedge clock_i) disable iff (rst_i)
        key_wr_i && state_o == rhai_pkg::LOCK_UNLOCKED
        |=> state_o == rhai_pkg::LOCK_LOCKED)
        else $error("key write did not relock");

    a_disabled_sticks: assert property (@(posedge clock_i) disable iff (rst_i)
        state_o == rhai_pkg::LOCK_DISABLED
        |=> state_o == rhai_pkg::LOCK_DISABLED)
        else $error("disabled state left without reset");

    a_reset_locks: assert property (@(posedge clock_i)
        rst_i |=> state_o == rhai_pkg::LOCK_LOCKED)
        else $error("reset did not lock");

    a_bad_access: assert property (@(posedge clock_i) disable iff (rst_i)
        bad_access_i && state_o != rhai_pkg::LOCK_UNLOCKED
        |=> state_o == rhai_pkg::LOCK_DISABLED)
        else $error("locked access did not disable");

endmodule : rhai_key_fsm

`default_nettype wire

/* File: rhai_clock_monitor.sv */
// missing-clock detector on the low-speed timebase pin
`timescale 1ns/1ns
`default_nettype none

module rhai_clock_monitor
#(
    parameter int unsigned TIMEOUT_CYCLES = rhai_pkg::MCD_TIMEOUT_CYCLES,
    parameter int unsigned CNT_W          = 16
)
(
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic timebase_i,
    input  wire logic enable_i,
    output logic      timeout_o
);

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYCLES);

    logic             tb_meta;
    logic             tb_sync;
    logic             tb_prev;
    logic             tb_edge;
    logic [CNT_W-1:0] idle_cnt;
    logic             fired;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, then edge detect
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            tb_meta <= 1'b0;
            tb_sync <= 1'b0;
            tb_prev <= 1'b0;
        end
        else
        begin
            tb_meta <= timebase_i;
            tb_sync <= tb_meta;
            tb_prev <= tb_sync;
        end
    end

    assign tb_edge = tb_sync ^ tb_prev;

    ////////////////////////////////////////////////////////////////////////
    // one-shot: fires once per stall, rearmed by the next edge
    always_ff @(posedge clock_i)
    begin
        if (rst_i || !enable_i || tb_edge)
        begin
            idle_cnt  <= '0;
            fired     <= 1'b0;
            timeout_o <= 1'b0;
        end
        else
        begin
            timeout_o <= 1'b0;
            if (!fired)
            begin
                if (idle_cnt == LIMIT)
                begin
                    timeout_o <= 1'b1;
                    fired     <= 1'b1;
                end
                else
                    idle_cnt <= idle_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_timeout_enabled: assert property (@(posedge clock_i) disable iff (rst_i)
        timeout_o |-> $past(enable_i) && !$past(tb_edge))
        else $error("timeout without enable or after edge");

    a_timeout_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
        timeout_o |=> !timeout_o)
        else $error("timeout longer than one cycle");

endmodule : rhai_clock_monitor

`default_nettype wire

/* File: rhai_top.sv */
// host access interface: key lock, indirect address/data, clock monitor
//
// What this block does
// - key register reads back the lock state
// - keys 0xA5 then 0xF1 unlock the interface
// - wrong second key disables until system reset
// - any key write while unlocked relocks
// - key writes ignored while disabled
// - wrong first key or locked access disables
// - writing busy starts read; busy while transferring
// - data register write starts indirect write
// - auto-read: data register read starts next read
// - backup above core sets regulator enable
// - short bit: strobe one clock, else four
// - four-bit select picks internal register
// - select increments after snapshot or match access
// - data register holds last transferred byte
// - address and data survive device reset
// - timebase independent; host access crosses domains
// - mode bit picks crystal or self-oscillation rate
// - detector flags stalled timebase over 50 us
// - timeout wakes, interrupts and resets if enabled
`timescale 1ns/1ns
`default_nettype none

module rhai_top
#(
    parameter int unsigned MCD_CYCLES = rhai_pkg::MCD_TIMEOUT_CYCLES
)
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    output logic      [7:0] sfr_rdata_o,
    output logic      [3:0] core_addr_o,
    output logic      [7:0] core_wdata_o,
    output logic            core_rd_o,
    output logic            core_wr_o,
    input  wire logic [7:0] core_rdata_i,
    input  wire logic       backup_above_core_i,
    output logic            backup_regulator_enable_o,
    input  wire logic       crystal_mode_select_i,
    input  wire logic       bias_doubling_enable_i,
    output logic      [1:0] osc_mode_o,
    input  wire logic       low_speed_timebase_i,
    input  wire logic       missing_clock_detect_enable_i,
    input  wire logic       irq_enable_i,
    input  wire logic       reset_source_enable_i,
    output logic            oscillator_fail_set_o,
    output logic            wake_o,
    output logic            irq_o,
    output logic            reset_req_o
);

    rhai_pkg::rhai_lock_t lock_state;
    rhai_pkg::rhai_xfer_t xfer;

    logic       sel_ctl;
    logic       sel_dat;
    logic       sel_key;
    logic       unlocked;
    logic       idle;
    logic       bad_access;
    logic       key_wr;
    logic       ctl_wr;
    logic       start_rd;
    logic       start_wr;
    logic       next_short;
    logic [2:0] next_width;
    logic [2:0] strobe_cnt;
    logic       done;
    logic       read_on_data_fetch_enable;
    logic       short_timing;
    logic       regulator_en;
    logic [3:0] internal_register_select;
    logic [7:0] data_byte;
    logic       backup_meta;
    logic       backup_sync;
    logic       mcd_timeout;

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign sel_ctl  = (sfr_addr_i == rhai_pkg::SFR_ADDR_CTRL);
    assign sel_dat  = (sfr_addr_i == rhai_pkg::SFR_DATA_PORT);
    assign sel_key  = (sfr_addr_i == rhai_pkg::SFR_KEY_STATE);
    assign unlocked = (lock_state == rhai_pkg::LOCK_UNLOCKED);
    assign idle     = (xfer == rhai_pkg::XFER_IDLE);
    assign key_wr   = sfr_wr_i && sel_key;

    // locked access to address or data ends in the disabled state
    assign bad_access = (sfr_wr_i || sfr_rd_i) && (sel_ctl || sel_dat)
                     && !unlocked;

    assign ctl_wr   = unlocked && idle && sfr_wr_i && sel_ctl;
    assign start_rd = unlocked && idle
                   && ((ctl_wr && sfr_wdata_i[rhai_pkg::BUSY_BIT])
                    || (sfr_rd_i && sel_dat
                        && read_on_data_fetch_enable));
    assign start_wr = unlocked && idle && sfr_wr_i && sel_dat;

    // a control write that starts a read also sets its own width
    assign next_short = ctl_wr ? sfr_wdata_i[rhai_pkg::SHORT_BIT]
                               : short_timing;
    assign next_width = next_short ? rhai_pkg::STROBE_SHORT
                                   : rhai_pkg::STROBE_LONG;
    assign done       = !idle && (strobe_cnt == 3'h1);

    ////////////////////////////////////////////////////////////////////////
    // lock and key
    rhai_key_fsm u_key
    (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .key_wr_i     (key_wr),
        .key_wdata_i  (sfr_wdata_i),
        .bad_access_i (bad_access),
        .state_o      (lock_state)
    );

    ////////////////////////////////////////////////////////////////////////
    // strobe engine toward the timebase-side registers; busy spans it
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            xfer       <= rhai_pkg::XFER_IDLE;
            strobe_cnt <= 3'h0;
            core_rd_o  <= 1'b0;
            core_wr_o  <= 1'b0;
        end
        else
        begin
            unique case (xfer)
                rhai_pkg::XFER_IDLE:
                begin
                    if (start_rd)
                    begin
                        xfer       <= rhai_pkg::XFER_READ;
                        core_rd_o  <= 1'b1;
                        strobe_cnt <= next_width;
                    end
                    else if (start_wr)
                    begin
                        xfer       <= rhai_pkg::XFER_WRITE;
                        core_wr_o  <= 1'b1;
                        strobe_cnt <= next_width;
                    end
                end
                rhai_pkg::XFER_READ,
                rhai_pkg::XFER_WRITE:
                begin
                    strobe_cnt <= strobe_cnt - 3'h1;
                    if (done)
                    begin
                        xfer      <= rhai_pkg::XFER_IDLE;
                        core_rd_o <= 1'b0;
                        core_wr_o <= 1'b0;
                    end
                end
                default:
                begin
                    xfer      <= rhai_pkg::XFER_IDLE;
                    core_rd_o <= 1'b0;
                    core_wr_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address/control fields: no reset so they survive device reset
    always_ff @(posedge clock_i)
    begin
        if (ctl_wr)
        begin
            read_on_data_fetch_enable <= sfr_wdata_i[rhai_pkg::READ_ON_DATA_FETCH_ENABLE_BIT];
            short_timing              <= sfr_wdata_i[rhai_pkg::SHORT_BIT];
            internal_register_select  <= sfr_wdata_i[rhai_pkg::SEL_MSB:0];
        end
        else if (done && rhai_pkg::rhai_autoinc(internal_register_select))
            internal_register_select <= internal_register_select + 4'h1;
    end

    // backup indication wins over a software clear
    always_ff @(posedge clock_i)
    begin
        if (backup_sync)
            regulator_en <= 1'b1;
        else if (ctl_wr)
            regulator_en <= sfr_wdata_i[rhai_pkg::REGEN_BIT];
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            backup_meta <= 1'b0;
            backup_sync <= 1'b0;
        end
        else
        begin
            backup_meta <= backup_above_core_i;
            backup_sync <= backup_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data port: no reset, holds the last byte moved
    always_ff @(posedge clock_i)
    begin
        if (start_wr)
            data_byte <= sfr_wdata_i;
        else if (done && xfer == rhai_pkg::XFER_READ)
            data_byte <= core_rdata_i;
    end

    assign core_addr_o               = internal_register_select;
    assign core_wdata_o              = data_byte;
    assign backup_regulator_enable_o = regulator_en;

    ////////////////////////////////////////////////////////////////////////
    // register read-back, one cycle after the read strobe
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i)
        begin
            if (sel_key)
                sfr_rdata_o <= {6'h00, lock_state};
            else if (sel_ctl && unlocked)
                sfr_rdata_o <= {!idle, read_on_data_fetch_enable,
                                regulator_en, short_timing,
                                internal_register_select};
            else if (sel_dat && unlocked)
                sfr_rdata_o <= data_byte;
            else
                sfr_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator mode and missing-clock events
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            osc_mode_o <= rhai_pkg::OSC_SELF_20K;
        else if (crystal_mode_select_i)
            osc_mode_o <= rhai_pkg::OSC_CRYSTAL;
        else
            osc_mode_o <= bias_doubling_enable_i ? rhai_pkg::OSC_SELF_40K
                                                 : rhai_pkg::OSC_SELF_20K;
    end

    rhai_clock_monitor #(.TIMEOUT_CYCLES (MCD_CYCLES)) u_mon
    (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .timebase_i (low_speed_timebase_i),
        .enable_i   (missing_clock_detect_enable_i),
        .timeout_o  (mcd_timeout)
    );

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            oscillator_fail_set_o <= 1'b0;
            wake_o                <= 1'b0;
            irq_o                 <= 1'b0;
            reset_req_o           <= 1'b0;
        end
        else
        begin
            oscillator_fail_set_o <= mcd_timeout;
            wake_o                <= mcd_timeout;
            irq_o                 <= mcd_timeout && irq_enable_i;
            reset_req_o           <= mcd_timeout && reset_source_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_busy_start: assert property (@(posedge clock_i) disable iff (rst_i)
        ctl_wr && sfr_wdata_i[rhai_pkg::BUSY_BIT]
        |=> core_rd_o && xfer == rhai_pkg::XFER_READ)
        else $error("busy write did not start a read");

    a_write_start: assert property (@(posedge clock_i) disable iff (rst_i)
        start_wr |=> core_wr_o && data_byte == $past(sfr_wdata_i))
        else $error("data write did not start a write");

    a_autoread: assert property (@(posedge clock_i) disable iff (rst_i)
        unlocked && idle && sfr_rd_i && sel_dat && read_on_data_fetch_enable
        |=> core_rd_o)
        else $error("auto-read did not start a read");

    a_short_strobe: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(core_rd_o || core_wr_o) && short_timing
        |=> !core_rd_o && !core_wr_o)
        else $error("short strobe not one cycle");

    a_long_strobe: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(core_rd_o || core_wr_o) && !short_timing
        |-> (core_rd_o || core_wr_o) [*4] ##1 !(core_rd_o || core_wr_o))
        else $error("long strobe not four cycles");

    a_regulator_set: assert property (@(posedge clock_i) disable iff (rst_i)
        backup_sync |=> regulator_en)
        else $error("regulator not set by backup");

    a_select_inc: assert property (@(posedge clock_i) disable iff (rst_i)
        done && rhai_pkg::rhai_autoinc(internal_register_select)
        |=> internal_register_select == $past(internal_register_select)
            + 4'h1)
        else $error("select did not increment");

    a_read_capture: assert property (@(posedge clock_i) disable iff (rst_i)
        done && xfer == rhai_pkg::XFER_READ
        |=> data_byte == $past(core_rdata_i) && !core_rd_o)
        else $error("read data not captured");

    a_irq_event: assert property (@(posedge clock_i) disable iff (rst_i)
        mcd_timeout && irq_enable_i |=> irq_o && wake_o)
        else $error("timeout did not interrupt");

endmodule : rhai_top

`default_nettype wire

/* File: rhai_core_model.sv */
// behavioural internal register file behind the indirect port
`timescale 1ns/1ns
`default_nettype none

module rhai_core_model
(
    input  wire logic       clock_i,
    input  wire logic [3:0] core_addr_i,
    input  wire logic [7:0] core_wdata_i,
    input  wire logic       core_rd_i,
    input  wire logic       core_wr_i,
    output logic      [7:0] core_rdata_o
);
    logic [7:0] mem [16];
    logic [7:0] idle = 8'h5A;

    initial for (int i = 0; i < 16; i++) mem[i] = 8'hC3 ^ 8'(i);
    // a written byte lands in the selected register
    always @(posedge clock_i)
        if (core_wr_i) mem[core_addr_i] <= core_wdata_i;
    // off-strobe data toggles so a stale capture shows
    always @(posedge clock_i) idle <= ~idle;
    assign core_rdata_o = core_rd_i ? mem[core_addr_i] : idle;
endmodule : rhai_core_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the clock host access interface
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam logic [7:0] AC = rhai_pkg::SFR_ADDR_CTRL;
    localparam logic [7:0] AD = rhai_pkg::SFR_DATA_PORT;
    localparam logic [7:0] KY = rhai_pkg::SFR_KEY_STATE;
    logic clock_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0;
    logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
    logic [7:0] core_wdata_o, core_rdata_i, d, v, shadow [16];
    logic [3:0] core_addr_o, s, es;
    logic [1:0] osc_mode_o;
    logic core_rd_o, core_wr_o, backup_regulator_enable_o, sh, ar;
    logic backup_above_core_i = 0, crystal_mode_select_i = 0;
    logic bias_doubling_enable_i = 0, low_speed_timebase_i = 0;
    logic missing_clock_detect_enable_i = 0, irq_enable_i = 1;
    logic reset_source_enable_i = 1, run = 0;
    logic oscillator_fail_set_o, wake_o, irq_o, reset_req_o;
    int failures = 0, n_checks = 0, n;

    always #5 clock_i = ~clock_i;
    // timebase pin moves on a falling edge, every fourth system cycle
    always
    begin
        repeat (4) @(negedge clock_i);
        if (run) low_speed_timebase_i = ~low_speed_timebase_i;
    end
    rhai_top #(.MCD_CYCLES(20)) dut (.clock_i, .rst_i, .sfr_addr_i,
        .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .core_addr_o,
        .core_wdata_o, .core_rd_o, .core_wr_o, .core_rdata_i,
        .backup_above_core_i, .backup_regulator_enable_o,
        .crystal_mode_select_i, .bias_doubling_enable_i, .osc_mode_o,
        .low_speed_timebase_i, .missing_clock_detect_enable_i,
        .irq_enable_i, .reset_source_enable_i, .oscillator_fail_set_o,
        .wake_o, .irq_o, .reset_req_o);
    rhai_core_model model (.clock_i(clock_i), .core_addr_i(core_addr_o),
        .core_wdata_i(core_wdata_o), .core_rd_i(core_rd_o),
        .core_wr_i(core_wr_o), .core_rdata_o(core_rdata_i));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] step(input logic [3:0] a);
        return (a <= 4'h5 || (a >= 4'h8 && a <= 4'hD)) ? a + 4'h1 : a;
    endfunction : step
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one bus access; read data is taken one cycle after the strobe
    task automatic acc(input logic [7:0] a, input logic w, [7:0] x);
        @(negedge clock_i);
        {sfr_addr_i, sfr_wdata_i, sfr_wr_i, sfr_rd_i} = {a, x, w, !w};
        @(negedge clock_i);
        {sfr_wr_i, sfr_rd_i} = 2'b00;
        d = sfr_rdata_o;
    endtask : acc
    task automatic wait_idle();
        for (int i = 0; i < 16; i++)
        begin
            acc(AC, 0, 0);
            if (d[7] === 1'b0) return;
        end
        failures++;
        conclude();
    endtask : wait_idle
    task automatic sys_reset();
        @(negedge clock_i) rst_i = 1;
        @(negedge clock_i) rst_i = 0;
        acc(KY, 0, 0); chk("key after reset", 8'h00, d);
    endtask : sys_reset
    task automatic unlock();
        acc(KY, 1, rhai_pkg::KEY_FIRST);
        acc(KY, 0, 0); chk("key first", 8'h01, d);
        acc(KY, 1, rhai_pkg::KEY_SECOND);
        acc(KY, 0, 0); chk("key open", 8'h02, d);
    endtask : unlock

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        n = $urandom(45);
        for (int i = 0; i < 16; i++) shadow[i] = 8'hC3 ^ 8'(i);
        repeat (6) @(negedge clock_i);
        rst_i = 0;
        acc(KY, 0, 0); chk("key reset", 8'h00, d);
        unlock();
        for (int t = 0; t < 10; t++)
        begin
            s = t < 2 ? 4'h5 + 4'(t * 8) : 4'($urandom);
            {v, sh, ar} = {8'($urandom), 1'($urandom), 1'($urandom)};
            acc(AC, 1, {3'b000, sh, s});
            acc(AD, 1, v);
            wait_idle();
            {shadow[s], es} = {v, step(s)};
            chk("select", {3'b000, sh, es}, d);
            acc(AC, 1, {1'b1, ar, 1'b0, sh, s});
            for (n = 0; core_rd_o === 1'b1 && n < 8; n++) @(negedge clock_i);
            chk("strobe width", sh ? 8'd1 : 8'd4, 8'(n));
            wait_idle();
            es = step(s);
            acc(AD, 0, 0); chk("read data", shadow[s], d);
            chk("auto read", {7'd0, ar}, {7'd0, core_rd_o});
            if (ar) es = step(es);
            wait_idle();
        end
        backup_above_core_i = 1;
        acc(AC, 1, {4'h0, es}); acc(AC, 0, 0);
        chk("regulator set", {4'h2, es}, d);
        backup_above_core_i = 0;
        acc(AC, 1, {4'h0, es}); acc(AC, 1, {4'h0, es}); acc(AC, 0, 0);
        chk("regulator off", {4'h0, es}, d);
        acc(AC, 1, {4'h2, es}); acc(AC, 0, 0);
        chk("regulator pin", 8'h01, {7'd0, backup_regulator_enable_o});
        $display("transfer test done");
        sys_reset();
        unlock();
        acc(AC, 0, 0); chk("kept select", {4'h0, es}, {4'h0, d[3:0]});
        acc(KY, 1, 8'h33); acc(KY, 0, 0); chk("relock", 8'h00, d);
        acc(KY, 1, rhai_pkg::KEY_FIRST);
        acc(KY, 1, 8'h00); acc(KY, 0, 0); chk("bad second", 8'h03, d);
        acc(KY, 1, rhai_pkg::KEY_FIRST);
        acc(KY, 0, 0); chk("disabled", 8'h03, d);
        sys_reset();
        acc(KY, 1, 8'h5A); acc(KY, 0, 0); chk("bad first", 8'h03, d);
        sys_reset();
        acc(AC, 0, 0); chk("locked read", 8'h00, d);
        acc(KY, 0, 0); chk("locked access", 8'h03, d);
        $display("lock test done");
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock_i);
            {crystal_mode_select_i, bias_doubling_enable_i} = 2'(i);
            repeat (2) @(negedge clock_i);
            chk("osc mode", i > 1 ? 8'd2 : 8'(i), {6'd0, osc_mode_o});
        end
        {run, missing_clock_detect_enable_i} = 2'b11;
        for (n = 0; n < 60 && irq_o !== 1'b1; n++) @(negedge clock_i);
        chk("no stall event", 8'd60, 8'(n));
        run = 0;
        for (n = 0; n < 80 && irq_o !== 1'b1; n++) @(negedge clock_i);
        chk("stall irq", 8'd1, {7'd0, irq_o});
        chk("events", 8'h07, {5'd0, wake_o, reset_req_o,
            oscillator_fail_set_o});
        {irq_enable_i, reset_source_enable_i, run} = 3'b001;
        repeat (10) @(negedge clock_i);
        run = 0;
        for (n = 0; n < 80 && wake_o !== 1'b1; n++) @(negedge clock_i);
        chk("gated events", 8'h05, {5'd0, wake_o, reset_req_o,
            oscillator_fail_set_o});
        chk("gated irq", 8'h00, {7'd0, irq_o});
        $display("detector test done");
        conclude();
    end
endmodule : tb
`default_nettype wire
